//--- src/hsf_pkg.sv
// Package for the high-side fault shutdown control register block
//
// Behaviour
// - Bits 14..12 enable per-switch overvoltage recovery
// - Bit 11 picks all or individual overtemp shutdown
// - Normal mode bits 9..7 disable overvoltage shutdown
// - Low-power bit 6 disables overvoltage shutdown
// - Bit 5 zero lets undervoltage shut switches
// - Bit 3 enables undervoltage recovery for all
// - Reserved bits ignore writes, read zero
// - Reset clears all; restart keeps configurable bits
package hsf_pkg;

	// ==========================================================
	// Register map
	localparam logic [6:0]  HSF_REG_ADDR  = 7'h07; // Register address
	localparam logic [15:0] HSF_RESET_VAL = 16'h0000; // Reset value
	localparam logic [15:0] HSF_WR_MASK   = 16'h7be8; // Writable bits

	// ==========================================================
	// Field positions
	localparam int HSF_OV_REC_LSB  = 12; // Overvoltage recovery, 3 bits
	localparam int HSF_OT_INDIV    = 11; // Overtemp individual select
	localparam int HSF_OV_SDN_LSB  = 7;  // Normal mode ov shutdown off
	localparam int HSF_LP_OV_OFF   = 6;  // Low-power ov shutdown off
	localparam int HSF_UV_SDN_OFF  = 5;  // Undervoltage shutdown off
	localparam int HSF_UV_REC      = 3;  // Undervoltage recovery

	// ==========================================================
	// Operating modes of the device
	typedef enum logic [1:0]
	{
		HSF_MODE_NORMAL = 2'b00, // Normal mode
		HSF_MODE_STOP   = 2'b01, // Stop mode
		HSF_MODE_SLEEP  = 2'b10, // Sleep mode
		HSF_MODE_OTHER  = 2'b11  // Any other mode
	} hsf_mode_t;

	// Register write request from the serial interface
	typedef struct packed
	{
		logic        wr_en;   // One-cycle write strobe
		logic [6:0]  addr;    // Register address
		logic [15:0] wdata;   // Write data
	} hsf_wr_t;

	// Fault indications from the supply and thermal detectors
	typedef struct packed
	{
		logic       overvolt;  // Supply overvoltage level
		logic       undervolt; // Supply undervoltage level
		logic [2:0] overtemp;  // Per-switch overtemperature level
	} hsf_fault_t;

endpackage : hsf_pkg

//--- src/hsf_ctrl.sv
// Fault shutdown control register and per-switch gating logic
`timescale 1ns/1ps
`default_nettype none
module hsf_ctrl
	import hsf_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// Soft reset and restart, one-cycle pulses
	input  wire logic        soft_rst,
	input  wire logic        restart,
	// Register access
	input  wire hsf_wr_t     wr,
	input  wire logic [6:0]  rd_addr,
	output logic      [15:0] rd_data,
	// Device state and faults
	input  wire hsf_mode_t   mode,
	input  wire hsf_fault_t  fault,
	// Requested and gated switch states
	input  wire logic [2:0]  sw_req,
	output logic      [2:0]  sw_en
);

	// ==========================================================
	// Reset synchroniser
	logic rst_s1_r; // First stage, read only by second
	logic rst_s2_r; // Synchronised reset, active low

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	// ==========================================================
	// Address decode
	// Shared by the write and read paths, so both agree on the map
	function automatic logic hit_reg(input logic [6:0] a);
		return (a == HSF_REG_ADDR);
	endfunction : hit_reg

	// ==========================================================
	// Configuration register
	logic [15:0] cfg_r;   // Stored configuration
	logic [15:0] cfg_nxt; // Next configuration

	// Soft reset clears; restart leaves configurable bits alone
	always_comb
	begin
		cfg_nxt = cfg_r;
		if (soft_rst)
			cfg_nxt = HSF_RESET_VAL;
		else if (wr.wr_en && hit_reg(wr.addr))
			cfg_nxt = wr.wdata & HSF_WR_MASK;
		// Restart only forces reserved bits, already zero
		else if (restart)
			cfg_nxt = cfg_r & HSF_WR_MASK;
	end

	// ==========================================================
	// Latched off state per switch, held until recovery allowed
	logic [2:0] ov_off_r;  // Switched off by overvoltage
	logic [2:0] ov_off_nxt;
	logic [2:0] uv_off_r;  // Switched off by undervoltage
	logic [2:0] uv_off_nxt;
	logic [2:0] ot_off;    // Overtemp shutdown, combinational
	logic [2:0] ov_sd;     // Overvoltage shutdown allowed
	logic       uv_sd;     // Undervoltage shutdown allowed
	logic [2:0] sw_nxt;    // Next gated switch state
	logic [15:0] rd_nxt;   // Next read data

	always_comb
	begin
		// Overvoltage shutdown selection depends on mode
		if (mode == HSF_MODE_NORMAL)
			ov_sd = ~cfg_r[HSF_OV_SDN_LSB +: 3];
		else if (mode == HSF_MODE_STOP || mode == HSF_MODE_SLEEP)
			ov_sd = {3{~cfg_r[HSF_LP_OV_OFF]}};
		else
			ov_sd = 3'b111;
		uv_sd = ~cfg_r[HSF_UV_SDN_OFF];
		// Overtemp: any detector kills all unless individual
		if (cfg_r[HSF_OT_INDIV])
			ot_off = fault.overtemp;
		else
			ot_off = {3{|fault.overtemp}};
		// Overvoltage latch: released at end only with recovery
		ov_off_nxt = ov_off_r;
		if (fault.overvolt)
			ov_off_nxt = ov_off_r | (ov_sd & sw_req);
		else
			ov_off_nxt = ov_off_r & ~cfg_r[HSF_OV_REC_LSB +: 3];
		// Undervoltage latch; recovery bit releases all switches
		uv_off_nxt = uv_off_r;
		if (fault.undervolt)
			uv_off_nxt = uv_off_r | ({3{uv_sd}} & sw_req);
		else if (cfg_r[HSF_UV_REC])
			uv_off_nxt = 3'b000;
		// A new off request from host also clears held shutdowns
		ov_off_nxt = ov_off_nxt & sw_req;
		uv_off_nxt = uv_off_nxt & sw_req;
		sw_nxt = sw_req & ~ov_off_nxt & ~uv_off_nxt & ~ot_off;
		// Unmapped addresses read zero
		rd_nxt = hit_reg(rd_addr) ? cfg_r : 16'h0000;
	end

	// ==========================================================
	// State registers
	always_ff @(posedge mclk or negedge rst_s2_r)
	begin
		if (!rst_s2_r)
		begin
			cfg_r    <= 16'h0000;
			ov_off_r <= 3'h0;
			uv_off_r <= 3'h0;
			sw_en    <= 3'h0;
			rd_data  <= 16'h0000;
		end
		else
		begin
			cfg_r    <= cfg_nxt;
			ov_off_r <= ov_off_nxt;
			uv_off_r <= uv_off_nxt;
			sw_en    <= sw_nxt;
			rd_data  <= rd_nxt;
		end
	end

	// ==========================================================
	// Checks
	a_rsvd_zero: assert property (@(posedge mclk) disable iff (!rst_s2_r)
		(cfg_r & ~HSF_WR_MASK) == 16'h0000)
		else $error("Reserved bit set");
	a_soft_clear: assert property (@(posedge mclk) disable iff (!rst_s2_r)
		soft_rst |=> cfg_r == 16'h0000)
		else $error("Soft reset did not clear");
	a_restart_keep: assert property (@(posedge mclk) disable iff (!rst_s2_r)
		(restart && !soft_rst && !wr.wr_en) |=> $stable(cfg_r))
		else $error("Restart changed config");
	a_ot_all: assert property (@(posedge mclk) disable iff (!rst_s2_r)
		(!cfg_r[HSF_OT_INDIV] && |fault.overtemp) |=> sw_en == 3'b000)
		else $error("Overtemp did not stop all");
	a_ot_indiv: assert property (@(posedge mclk) disable iff (!rst_s2_r)
		(cfg_r[HSF_OT_INDIV] && fault.overtemp[0]) |=> !sw_en[0])
		else $error("Overtemp switch still on");
	a_uv_off: assert property (@(posedge mclk) disable iff (!rst_s2_r)
		(fault.undervolt && !cfg_r[HSF_UV_SDN_OFF]) |=> sw_en == 3'b000)
		else $error("Undervoltage did not stop");
	a_uv_keep: assert property (@(posedge mclk) disable iff (!rst_s2_r)
		(fault.undervolt && cfg_r[HSF_UV_SDN_OFF] && !fault.overvolt
		&& fault.overtemp == 3'b000 && uv_off_r == 3'b000
		&& ov_off_r == 3'b000) |=> sw_en == $past(sw_req))
		else $error("Undervoltage shut despite off");
	a_ov_normal: assert property (@(posedge mclk) disable iff (!rst_s2_r)
		(fault.overvolt && mode == HSF_MODE_NORMAL && !cfg_r[7])
		|=> !sw_en[0])
		else $error("Normal ov did not stop sw1");
	a_ov_lowpwr: assert property (@(posedge mclk) disable iff (!rst_s2_r)
		(fault.overvolt && mode == HSF_MODE_STOP && !cfg_r[6])
		|=> sw_en == 3'b000)
		else $error("Low-power ov did not stop");
	a_ov_norec: assert property (@(posedge mclk) disable iff (!rst_s2_r)
		(ov_off_r[0] && !cfg_r[12] && !wr.wr_en && !soft_rst)
		|=> !sw_en[0])
		else $error("Switch recovered without enable");
	a_uv_norec: assert property (@(posedge mclk) disable iff (!rst_s2_r)
		(uv_off_r[1] && !cfg_r[3] && !wr.wr_en && !soft_rst)
		|=> !sw_en[1])
		else $error("Uv recovery without enable");

	// ==========================================================
	// Checks on kept and recovered switches, sleep shutdown and reads
	// The keep checks guard that a disabled shutdown really leaves the
	// switch alone, the recover checks that the latch lets it go again
	a_ov_sleep: assert property (@(posedge mclk) disable iff (!rst_s2_r)
		(fault.overvolt && mode == HSF_MODE_SLEEP && !cfg_r[6])
		|=> sw_en == 3'b000)
		else $error("Sleep ov did not stop");
	a_ov_lp_keep: assert property (@(posedge mclk) disable iff (!rst_s2_r)
		(fault.overvolt && cfg_r[6] && !fault.undervolt
		&& (mode == HSF_MODE_STOP || mode == HSF_MODE_SLEEP)
		&& fault.overtemp == 3'b000 && ov_off_r == 3'b000
		&& uv_off_r == 3'b000) |=> sw_en == $past(sw_req))
		else $error("Low-power ov shut despite off");
	a_ov_norm_keep: assert property (@(posedge mclk) disable iff (!rst_s2_r)
		(fault.overvolt && mode == HSF_MODE_NORMAL && cfg_r[7]
		&& !fault.undervolt && fault.overtemp == 3'b000
		&& !ov_off_r[0] && !uv_off_r[0])
		|=> sw_en[0] == $past(sw_req[0]))
		else $error("Normal ov shut sw1 despite off");
	a_ov_recover: assert property (@(posedge mclk) disable iff (!rst_s2_r)
		(!fault.overvolt && !fault.undervolt && cfg_r[12]
		&& fault.overtemp == 3'b000 && !uv_off_r[0])
		|=> sw_en[0] == $past(sw_req[0]))
		else $error("Sw1 did not recover after ov");
	a_uv_recover: assert property (@(posedge mclk) disable iff (!rst_s2_r)
		(!fault.undervolt && !fault.overvolt && cfg_r[3]
		&& fault.overtemp == 3'b000 && !ov_off_r[1])
		|=> sw_en[1] == $past(sw_req[1]))
		else $error("Sw2 did not recover after uv");
	a_ot_spare: assert property (@(posedge mclk) disable iff (!rst_s2_r)
		(cfg_r[11] && fault.overtemp == 3'b001 && !fault.overvolt
		&& !fault.undervolt && ov_off_r == 3'b000
		&& uv_off_r == 3'b000)
		|=> sw_en[2:1] == $past(sw_req[2:1]))
		else $error("Overtemp hit a cool switch");
	a_rd_unmapped: assert property (@(posedge mclk) disable iff (!rst_s2_r)
		(rd_addr != HSF_REG_ADDR) |=> rd_data == 16'h0000)
		else $error("Unmapped read not zero");
	// Unlisted modes fail safe: overvoltage always shuts down
	a_ov_other: assert property (@(posedge mclk) disable iff (!rst_s2_r)
		(fault.overvolt && mode == HSF_MODE_OTHER) |=> sw_en == 3'b000)
		else $error("Other-mode ov did not stop");

endmodule : hsf_ctrl
`default_nettype wire

//--- sim/hsf_host.sv
// Host model that reaches the shutdown control register
`timescale 1ns/1ps
`default_nettype none
module hsf_host
	import hsf_pkg::*;
(
	// Clock
	input  wire logic        mclk,
	// Register access
	output var hsf_wr_t      wr,
	output logic      [6:0]  rd_addr,
	input  wire logic [15:0] rd_data
);
	// ==========================================================
	// Idle bus at time zero
	initial
	begin
		wr      = '0;
		rd_addr = 7'h00;
	end

	// One-cycle write strobe, launched just after an edge
	task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
		@(posedge mclk);
		#1;
		wr = {1'b1, a, d};
		@(posedge mclk);
		#1;
		wr.wr_en = 1'b0;
	endtask : wr_reg

	// Read data is registered, so it lands one edge after the address
	task automatic rd_reg(input logic [6:0] a, output logic [15:0] d);
		@(posedge mclk);
		#1;
		rd_addr = a;
		@(posedge mclk);
		#1;
		d = rd_data;
	endtask : rd_reg
endmodule : hsf_host
`default_nettype wire

//--- sim/tb.sv
// Self-checking testbench for the fault shutdown control block
`timescale 1ns/1ps
`default_nettype none
module tb
	import hsf_pkg::*;
;
	// ==========================================================
	// Signals
	logic        mclk;
	logic        rst_n;
	logic        soft_rst;
	logic        restart;
	hsf_wr_t     wr;
	logic [6:0]  rd_addr;
	logic [15:0] rd_data;
	logic [15:0] v;
	hsf_mode_t   mode;
	hsf_fault_t  fault;
	logic [2:0]  sw_req;
	logic [2:0]  sw_en;
	int          num_errors;
	int          samples_checked;

	// 250 MHz clock
	always #2 mclk = ~mclk;

	hsf_ctrl DUT (.mclk(mclk), .rst_n(rst_n), .soft_rst(soft_rst),
		.restart(restart), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data),
		.mode(mode), .fault(fault), .sw_req(sw_req), .sw_en(sw_en));
	hsf_host host (.mclk(mclk), .wr(wr), .rd_addr(rd_addr),
		.rd_data(rd_data));

	// ==========================================================
	// Checking helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Apply fault levels, give latch and output register time to settle
	task automatic sw(input logic [4:0] f, input logic [2:0] e);
		fault = f;
		repeat (3) @(posedge mclk);
		#1;
		chk({13'h0000, sw_en}, {13'h0000, e});
	endtask : sw

	// Drop and restore requests, which clears any held shutdown
	task automatic rearm;
		sw_req = 3'h0;
		repeat (2) @(posedge mclk);
		#1;
		sw_req = 3'h7;
	endtask : rearm

	task automatic report_and_stop;
		$display("errors=%0d checks=%0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop

	// Hang guard: running out counts as a mismatch
	initial
	begin
		repeat (3000) @(posedge mclk);
		num_errors++;
		report_and_stop();
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		mclk = 1'b0;
		rst_n = 1'b0;
		soft_rst = 1'b0;
		restart = 1'b0;
		mode = HSF_MODE_NORMAL;
		fault = '0;
		sw_req = 3'h7;
		num_errors = 0;
		samples_checked = 0;
		repeat (4) @(posedge mclk);
		#1 rst_n = 1'b1;
		repeat (3) @(posedge mclk);
		host.rd_reg(HSF_REG_ADDR, v); chk(v, 16'h0000);
		host.wr_reg(HSF_REG_ADDR, 16'hffff);
		host.rd_reg(HSF_REG_ADDR, v); chk(v, 16'h7be8);
		host.wr_reg(7'h08, 16'h0000);
		host.rd_reg(HSF_REG_ADDR, v); chk(v, 16'h7be8);
		host.rd_reg(7'h08, v); chk(v, 16'h0000);
		// Restart keeps settings, soft reset wipes them
		restart = 1'b1;
		@(posedge mclk);
		#1 restart = 1'b0;
		host.rd_reg(HSF_REG_ADDR, v); chk(v, 16'h7be8);
		soft_rst = 1'b1;
		@(posedge mclk);
		#1 soft_rst = 1'b0;
		host.rd_reg(HSF_REG_ADDR, v); chk(v, 16'h0000);
		// Overvoltage: only switch 1 may shut in normal mode
		host.wr_reg(HSF_REG_ADDR, 16'h1300);
		sw(5'b10000, 3'b110);
		mode = HSF_MODE_STOP;
		sw(5'b10000, 3'b000);
		mode = HSF_MODE_NORMAL;
		sw(5'b00000, 3'b001);
		rearm();
		// Undervoltage with and without recovery or shutdown
		host.wr_reg(HSF_REG_ADDR, 16'h0008);
		sw(5'b01000, 3'b000);
		sw(5'b00000, 3'b111);
		host.wr_reg(HSF_REG_ADDR, 16'h0020);
		sw(5'b01000, 3'b111);
		host.wr_reg(HSF_REG_ADDR, 16'h0000);
		sw(5'b01000, 3'b000);
		sw(5'b00000, 3'b000);
		rearm();
		// Overtemperature, grouped then individual
		sw(5'b00001, 3'b000);
		host.wr_reg(HSF_REG_ADDR, 16'h0800);
		sw(5'b00001, 3'b110);
		sw(5'b00000, 3'b111);
		// Sleep mode: low-power bit keeps, then allows, shutdown
		mode = HSF_MODE_SLEEP;
		host.wr_reg(HSF_REG_ADDR, 16'h0040);
		sw(5'b10000, 3'b111);
		host.wr_reg(HSF_REG_ADDR, 16'h0000);
		sw(5'b10000, 3'b000);
		sw(5'b00000, 3'b000);
		rearm();
		// Unlisted mode ignores the normal-mode disable bits
		mode = HSF_MODE_OTHER;
		host.wr_reg(HSF_REG_ADDR, 16'h0380);
		sw(5'b10000, 3'b000);
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
